// ==== hw/pmd_top.sv ====
// Module: peripheral disable controls and signal routing selection registers
`timescale 1ns/10ps
module pmd_top #(
	parameter int N_IN = pmd_pkg::N_IN,
	parameter int N_PIN = pmd_pkg::N_PIN
) (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_bor_resetn,
	// AXI4-Lite
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Configuration
	input wire logic one_shot_route_lock,
	// Peripheral control
	output logic [pmd_pkg::DIS_W-1:0] periph_clk_en_q,
	output logic [pmd_pkg::DIS_W-1:0] periph_rst_hold_q,
	output logic peripheral_sysclk_gate_q,
	// Routing
	output logic [N_IN*pmd_pkg::IN_SEL_W-1:0] in_sel_q,
	output logic [N_IN-1:0] in_route_en_q,
	output logic [N_PIN*pmd_pkg::OUT_SRC_W-1:0] out_src_q,
	// Pin direction
	input wire logic [N_PIN-1:0] pin_direction_control,
	input wire logic [pmd_pkg::N_SRC-1:0] periph_dir_ovr,
	input wire logic [pmd_pkg::N_SRC-1:0] periph_dir_drive,
	output logic [N_PIN-1:0] pin_oe_n_q
);
	pmd_reg_if rif ();

	logic [pmd_pkg::DIS_W-1:0] dis_q, dis_d;
	logic [pmd_pkg::IN_SEL_W-1:0] isel_q [N_IN];
	logic [pmd_pkg::IN_SEL_W-1:0] isel_d [N_IN];
	logic [pmd_pkg::OUT_SRC_W-1:0] osel_q [N_PIN];
	logic [pmd_pkg::OUT_SRC_W-1:0] osel_d [N_PIN];
	logic [pmd_pkg::DIS_W-1:0] clk_en_d, rst_hold_d;
	logic sysclk_gate_d;
	logic [N_IN*pmd_pkg::IN_SEL_W-1:0] in_sel_d;
	logic [N_IN-1:0] in_route_en_d;
	logic [N_PIN*pmd_pkg::OUT_SRC_W-1:0] out_src_d;
	logic [N_PIN-1:0] pin_oe_n_d;
	logic cfg_meta_q, cfg_sync_q;
	logic locked, spent, armed;
	logic wr_lock, wr_other;
	logic [9:0] wr_word, rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave and lock sequencer
	pmd_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rif(rif)
	);

	// Lock write goes to the sequencer; any other write breaks the keys
	assign wr_lock = rif.wr_en && (rif.wr_addr[pmd_pkg::ADDR_W-1:2] == pmd_pkg::OFF_LOCK[pmd_pkg::ADDR_W-1:2]);
	assign wr_other = rif.wr_en && !wr_lock;

	pmd_lock_seq u_lock (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_lock(wr_lock),
		.wr_other(wr_other),
		.wr_data(rif.wr_data),
		.one_shot(cfg_sync_q),
		.locked_q(locked),
		.spent_q(spent),
		.armed(armed)
	);

	// Configuration level comes from a fuse domain; two flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_meta_q <= 1'b0;
			cfg_sync_q <= 1'b0;
		end else begin
			cfg_meta_q <= one_shot_route_lock;
			cfg_sync_q <= cfg_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Owner lookup: is the disable bit that owns a register set
	function automatic logic owner_off(input logic [pmd_pkg::OWN_W-1:0] own,
		input logic [pmd_pkg::DIS_W-1:0] dis);
		logic r;
		r = 1'b0;
		if (own != pmd_pkg::OWNER_NONE && int'(own) < pmd_pkg::DIS_W) begin
			r = dis[own];
		end
		return r;
	endfunction

	function automatic logic [pmd_pkg::OWN_W-1:0] in_owner(input int i);
		return pmd_pkg::IN_OWNER[i*pmd_pkg::OWN_W +: pmd_pkg::OWN_W];
	endfunction

	function automatic logic [pmd_pkg::OWN_W-1:0] src_owner(input logic [4:0] code);
		return pmd_pkg::SRC_OWNER[int'(code)*pmd_pkg::OWN_W +: pmd_pkg::OWN_W];
	endfunction

	assign wr_word = rif.wr_addr[pmd_pkg::ADDR_W-1:2];
	assign rd_word = rif.rd_addr[pmd_pkg::ADDR_W-1:2];

	////////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_comb begin
		int k;
		k = 0;
		dis_d = dis_q;
		isel_d = isel_q;
		osel_d = osel_q;
		rif.wr_err = 1'b1;
		for (int i = 0; i < pmd_pkg::N_DIS_REGS; i++) begin
			if (wr_word == 10'(int'(pmd_pkg::OFF_DIS_BASE[pmd_pkg::ADDR_W-1:2]) + i)) begin
				rif.wr_err = 1'b0;
				// Lock does not guard disables; only implemented bits move
				if (rif.wr_en) begin
					dis_d[i*8 +: 8] = rif.wr_data & pmd_pkg::DIS_MASK[i*8 +: 8];
				end
			end
		end
		if (wr_word == pmd_pkg::OFF_LOCK[pmd_pkg::ADDR_W-1:2] ||
			wr_word == pmd_pkg::OFF_STATUS[pmd_pkg::ADDR_W-1:2]) begin
			rif.wr_err = 1'b0;
		end
		for (int i = 0; i < N_IN; i++) begin
			k = int'(pmd_pkg::OFF_IN_BASE[pmd_pkg::ADDR_W-1:2]) + i;
			if (wr_word == 10'(k)) begin
				rif.wr_err = 1'b0;
				// Locked routing or a disabled owner drops the write silently
				if (rif.wr_en && !locked && !owner_off(in_owner(i), dis_q)) begin
					isel_d[i] = rif.wr_data[pmd_pkg::IN_SEL_W-1:0];
				end
			end
		end
		for (int j = 0; j < N_PIN; j++) begin
			k = int'(pmd_pkg::OFF_OUT_BASE[pmd_pkg::ADDR_W-1:2]) + j;
			if (wr_word == 10'(k)) begin
				rif.wr_err = 1'b0;
				if (rif.wr_en && !locked && !owner_off(src_owner(osel_q[j]), dis_q)) begin
					osel_d[j] = rif.wr_data[pmd_pkg::OUT_SRC_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads; unmapped words answer with an error and zero
	always_comb begin
		int k;
		k = 0;
		rif.rd_data = 8'h00;
		rif.rd_err = 1'b1;
		for (int i = 0; i < pmd_pkg::N_DIS_REGS; i++) begin
			if (rd_word == 10'(int'(pmd_pkg::OFF_DIS_BASE[pmd_pkg::ADDR_W-1:2]) + i)) begin
				rif.rd_err = 1'b0;
				rif.rd_data = dis_q[i*8 +: 8];
			end
		end
		if (rd_word == pmd_pkg::OFF_LOCK[pmd_pkg::ADDR_W-1:2]) begin
			rif.rd_err = 1'b0;
			rif.rd_data = {7'h00, locked} & pmd_pkg::LOCK_MASK;
		end
		if (rd_word == pmd_pkg::OFF_STATUS[pmd_pkg::ADDR_W-1:2]) begin
			rif.rd_err = 1'b0;
			rif.rd_data = 8'h00;
			rif.rd_data[pmd_pkg::STAT_LOCKED] = locked;
			rif.rd_data[pmd_pkg::STAT_SPENT] = spent;
			rif.rd_data[pmd_pkg::STAT_ARMED] = armed;
		end
		for (int i = 0; i < N_IN; i++) begin
			k = int'(pmd_pkg::OFF_IN_BASE[pmd_pkg::ADDR_W-1:2]) + i;
			if (rd_word == 10'(k)) begin
				rif.rd_err = 1'b0;
				// Disabled owner reads as zero
				if (!owner_off(in_owner(i), dis_q)) begin
					rif.rd_data = {2'b00, isel_q[i]} & pmd_pkg::IN_SEL_MASK;
				end
			end
		end
		for (int j = 0; j < N_PIN; j++) begin
			k = int'(pmd_pkg::OFF_OUT_BASE[pmd_pkg::ADDR_W-1:2]) + j;
			if (rd_word == 10'(k)) begin
				rif.rd_err = 1'b0;
				if (!owner_off(src_owner(osel_q[j]), dis_q)) begin
					rif.rd_data = {3'b000, osel_q[j]} & pmd_pkg::OUT_SRC_MASK;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Disable bits clear on any reset; routing only on power-on
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_bor_resetn) begin
			dis_q <= '0;
		end else begin
			dis_q <= dis_d;
		end
	end

	// Routing selections survive ordinary resets
	always_ff @(posedge aclk) begin
		if (!por_bor_resetn) begin
			for (int i = 0; i < N_IN; i++) begin
				isel_q[i] <= pmd_pkg::IN_DEFAULT[i*pmd_pkg::IN_SEL_W +: pmd_pkg::IN_SEL_W];
			end
			for (int j = 0; j < N_PIN; j++) begin
				osel_q[j] <= '0;
			end
		end else if (aresetn) begin
			isel_q <= isel_d;
			osel_q <= osel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Peripheral gates, routing outputs and pin direction
	always_comb begin
		logic [pmd_pkg::OUT_SRC_W-1:0] code;
		code = '0;
		// Gate and hold come from the next disable value, so they track it
		clk_en_d = ~dis_d & pmd_pkg::DIS_MASK;
		rst_hold_d = dis_d & pmd_pkg::DIS_MASK;
		sysclk_gate_d = ~dis_d[pmd_pkg::SYSCLK_GATE_BIT];
		for (int i = 0; i < N_IN; i++) begin
			in_sel_d[i*pmd_pkg::IN_SEL_W +: pmd_pkg::IN_SEL_W] = isel_q[i];
			in_route_en_d[i] = !owner_off(in_owner(i), dis_d);
		end
		for (int j = 0; j < N_PIN; j++) begin
			code = osel_q[j];
			// A disabled source parks the pin on the port latch
			if (owner_off(src_owner(code), dis_d)) begin
				code = '0;
			end
			out_src_d[j*pmd_pkg::OUT_SRC_W +: pmd_pkg::OUT_SRC_W] = code;
			// Peripheral takes direction over the port when it asks
			if (code != '0 && periph_dir_ovr[code]) begin
				pin_oe_n_d[j] = !periph_dir_drive[code];
			end else begin
				pin_oe_n_d[j] = pin_direction_control[j];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !por_bor_resetn) begin
			periph_clk_en_q <= pmd_pkg::DIS_MASK;
			periph_rst_hold_q <= '0;
			peripheral_sysclk_gate_q <= 1'b1;
			in_sel_q <= pmd_pkg::IN_DEFAULT;
			in_route_en_q <= '1;
			out_src_q <= '0;
			pin_oe_n_q <= '1;
		end else begin
			periph_clk_en_q <= clk_en_d;
			periph_rst_hold_q <= rst_hold_d;
			peripheral_sysclk_gate_q <= sysclk_gate_d;
			in_sel_q <= in_sel_d;
			in_route_en_q <= in_route_en_d;
			out_src_q <= out_src_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end
endmodule

// ==== hw/pmd_pkg.sv ====
// Package: register map, field layouts, reset values and lock codes for module disable and routing
//
// Functional notes
// - Input select: six bits, bits 7:6 read zero
// - Output source: five bits, power-on clear only
// - Routed peripheral overrides pin direction when driving
// - Lock flag bit 0; set blocks routing writes
// - Lock flag changes only after 0x55, 0xAA
// - One-shot option: clear then set once only
// - Disable bits clear on every reset
// - Disabled peripheral gets no clock or control
// - Disabled peripheral held reset, registers read zero
// - Re-enabled peripheral starts from its reset state
// - Disable also disables that peripheral's routing registers
// - Bit 7 of control 0 gates system clock
// - One disables, zero enables, unimplemented read zero
package pmd_pkg;
	localparam int ADDR_W = 12;
	localparam int N_DIS_REGS = 6;
	localparam int DIS_W = 48;
	localparam int N_IN = 20;
	localparam int N_PIN = 18;
	localparam int IN_SEL_W = 6;
	localparam int OUT_SRC_W = 5;
	localparam int OWN_W = 6;
	localparam int N_SRC = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Byte offsets of the register words
	localparam logic [ADDR_W-1:0] OFF_DIS_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_LOCK = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h01c;
	localparam logic [ADDR_W-1:0] OFF_IN_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_OUT_BASE = 12'h100;

	// Implemented disable bits, control 5 in the top byte
	localparam logic [DIS_W-1:0] DIS_MASK = {8'h1e, 8'hd1, 8'h3f, 8'h67, 8'h87, 8'hc7};
	localparam int SYSCLK_GATE_BIT = 7;
	localparam logic [7:0] IN_SEL_MASK = 8'h3f;
	localparam logic [7:0] OUT_SRC_MASK = 8'h1f;
	localparam logic [7:0] LOCK_MASK = 8'h01;
	localparam logic [7:0] LOCK_KEY1 = 8'h55;
	localparam logic [7:0] LOCK_KEY2 = 8'haa;
	localparam logic [OWN_W-1:0] OWNER_NONE = 6'h3f;
	localparam int STAT_LOCKED = 0;
	localparam int STAT_SPENT = 1;
	localparam int STAT_ARMED = 2;

	// Input select defaults, entry 0 in the low bits
	localparam logic [N_IN*IN_SEL_W-1:0] IN_DEFAULT = {
		6'h10, 6'h11, 6'h14, 6'h15, 6'h13, 6'h11, 6'h10, 6'h12, 6'h05, 6'h11,
		6'h14, 6'h13, 6'h02, 6'h13, 6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02};
	// Disable bit that owns each input; shared inputs have no owner
	localparam logic [N_IN*OWN_W-1:0] IN_OWNER = {
		6'h27, 6'h27, 6'h26, 6'h26, 6'h24, 6'h24, 6'h24, 6'h15, 6'h3f, 6'h3f,
		6'h3f, 6'h3f, 6'h20, 6'h19, 6'h18, 6'h0a, 6'h09, 6'h09, 6'h08, 6'h3f};
	// Disable bit that owns each output source code
	localparam logic [N_SRC*OWN_W-1:0] SRC_OWNER = {
		6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h01, 6'h0f, 6'h08, 6'h3f, 6'h3f, 6'h24, 6'h24,
		6'h12, 6'h11, 6'h27, 6'h27, 6'h26, 6'h26, 6'h1d, 6'h1c, 6'h1b, 6'h1a, 6'h19,
		6'h18, 6'h20, 6'h20, 6'h20, 6'h20, 6'h2c, 6'h2b, 6'h2a, 6'h29, 6'h3f};

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b001,
		LK_KEY1 = 3'b010,
		LK_ARMED = 3'b100
	} pmd_lock_e;
endpackage

// ==== hw/pmd_reg_if.sv ====
// Interface: register access strobes between bus slave and register file
`timescale 1ns/10ps
interface pmd_reg_if;
	logic wr_en;
	logic [pmd_pkg::ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_err;
	logic rd_en;
	logic [pmd_pkg::ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_err;

	modport bus (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input wr_err, rd_data, rd_err);
	modport regs (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// ==== hw/pmd_axil_slave.sv ====
// Module: AXI4-Lite slave turning bus beats into one-cycle register strobes
`timescale 1ns/10ps
module pmd_axil_slave (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	pmd_reg_if.bus rif
);
	logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
	logic rvalid_q, rvalid_d;
	logic [pmd_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wdata_q, wdata_d;
	logic wlane_q, wlane_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] rdata_q, rdata_d;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

	////////////////////////////////////////////////////////////////////////////////
	// Address and data are latched apart, so either may come first
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (awvalid && awready) begin
			aw_held_d = 1'b1;
			awaddr_d = awaddr[pmd_pkg::ADDR_W-1:0];
		end
		if (wvalid && wready) begin
			w_held_d = 1'b1;
			wdata_d = wdata[7:0];
			wlane_d = wstrb[0];
		end
		if (rif.wr_en) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = rif.wr_err ? pmd_pkg::RESP_SLVERR : pmd_pkg::RESP_OKAY;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		// Readies follow the next held state, so each leaves a flop
		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
	end

	// Read answered on the same edge that takes the address
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rif.rd_en) begin
			rvalid_d = 1'b1;
			rdata_d = rif.rd_data;
			rresp_d = rif.rd_err ? pmd_pkg::RESP_SLVERR : pmd_pkg::RESP_OKAY;
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 8'h00;
			wlane_q <= 1'b0;
			bresp_q <= pmd_pkg::RESP_OKAY;
			rresp_q <= pmd_pkg::RESP_OKAY;
			rdata_q <= 8'h00;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wlane_q <= wlane_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	// A write whose low byte lane is off still answers, and stores zero
	assign rif.wr_en = aw_held_q && w_held_q && !bvalid_q;
	assign rif.wr_addr = awaddr_q;
	assign rif.wr_data = wlane_q ? wdata_q : 8'h00;
	assign rif.rd_en = arvalid && arready;
	assign rif.rd_addr = araddr[pmd_pkg::ADDR_W-1:0];
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = {24'h000000, rdata_q};
endmodule

// ==== hw/pmd_lock_seq.sv ====
// Module: unlock key sequence and one-shot policy for the routing lock flag
`timescale 1ns/10ps
module pmd_lock_seq (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register strobes
	input wire logic wr_lock,
	input wire logic wr_other,
	input wire logic [7:0] wr_data,
	// Configuration
	input wire logic one_shot,
	// State
	output logic locked_q,
	output logic spent_q,
	output logic armed
);
	pmd_pkg::pmd_lock_e st_q, st_d;
	logic locked_d, spent_d;

	////////////////////////////////////////////////////////////////////////////////
	// Any stray write breaks the key sequence, so only adjacent writes unlock
	always_comb begin
		st_d = st_q;
		locked_d = locked_q;
		spent_d = spent_q;
		if (wr_other) begin
			st_d = pmd_pkg::LK_IDLE;
		end else if (wr_lock) begin
			case (st_q)
				pmd_pkg::LK_IDLE: begin
					st_d = (wr_data == pmd_pkg::LOCK_KEY1) ? pmd_pkg::LK_KEY1 : pmd_pkg::LK_IDLE;
				end
				pmd_pkg::LK_KEY1: begin
					st_d = (wr_data == pmd_pkg::LOCK_KEY2) ? pmd_pkg::LK_ARMED : pmd_pkg::LK_IDLE;
				end
				pmd_pkg::LK_ARMED: begin
					st_d = pmd_pkg::LK_IDLE;
					// One-shot: once set, the flag holds until the next reset
					if (!(one_shot && spent_q)) begin
						locked_d = wr_data[0];
						spent_d = spent_q | (one_shot & wr_data[0]);
					end
				end
				default: st_d = pmd_pkg::LK_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= pmd_pkg::LK_IDLE;
			locked_q <= 1'b0;
			spent_q <= 1'b0;
		end else begin
			st_q <= st_d;
			locked_q <= locked_d;
			spent_q <= spent_d;
		end
	end

	assign armed = (st_q == pmd_pkg::LK_ARMED);
endmodule

// ==== verif/pmd_top_chk.sv ====
// Checker: port properties of the disable controls and routing registers
`timescale 1ns/10ps
module pmd_top_chk #(
	parameter int N_IN = pmd_pkg::N_IN,
	parameter int N_PIN = pmd_pkg::N_PIN
) (
	// Clock and resets
	input logic aclk,
	input logic aresetn,
	input logic por_bor_resetn,
	// Bus
	input logic bvalid,
	// Peripheral control
	input logic [pmd_pkg::DIS_W-1:0] periph_clk_en_q,
	input logic [pmd_pkg::DIS_W-1:0] periph_rst_hold_q,
	input logic peripheral_sysclk_gate_q,
	// Routing and direction
	input logic [N_IN-1:0] in_route_en_q,
	input logic [N_PIN*pmd_pkg::OUT_SRC_W-1:0] out_src_q,
	input logic [N_PIN-1:0] pin_direction_control,
	input logic [pmd_pkg::N_SRC-1:0] periph_dir_ovr,
	input logic [pmd_pkg::N_SRC-1:0] periph_dir_drive,
	input logic [N_PIN-1:0] pin_oe_n_q
);
	logic [N_IN-1:0] exp_en;
	logic [N_PIN-1:0] exp_oe;
	logic bad_src;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !por_bor_resetn);

	////////////////////////////////////////
	// Expected enables and drivers; owner tables keep shared inputs always on
	always_comb begin
		logic [5:0] o;
		logic [4:0] s;
		o = '0;
		s = '0;
		bad_src = '0;
		for (int i = 0; i < N_IN; i++) begin
			o = pmd_pkg::IN_OWNER[6*i+:6];
			exp_en[i] = (o == pmd_pkg::OWNER_NONE) ? '1 : !periph_rst_hold_q[o];
		end
		for (int j = 0; j < N_PIN; j++) begin
			s = out_src_q[5*j+:5];
			o = pmd_pkg::SRC_OWNER[6*s+:6];
			exp_oe[j] = periph_dir_ovr[s] ? !periph_dir_drive[s] : pin_direction_control[j];
			if (s != '0 && o != pmd_pkg::OWNER_NONE && periph_rst_hold_q[o])
				bad_src = '1;
		end
	end

	////////////////////////////////////////
	// Gate and hold come from the same disable bit
	a_clk_gate_match: assert property (
		periph_clk_en_q == (~periph_rst_hold_q & pmd_pkg::DIS_MASK))
		else $error("clock enable disagrees with reset hold");
	a_hold_impl_only: assert property (
		(periph_rst_hold_q & ~pmd_pkg::DIS_MASK) == '0)
		else $error("unimplemented disable position set");
	a_sysclk_follow: assert property (
		peripheral_sysclk_gate_q == !periph_rst_hold_q[pmd_pkg::SYSCLK_GATE_BIT])
		else $error("system clock gate wrong");
	a_dis_reset_zero: assert property (
		$rose(aresetn) |-> periph_rst_hold_q == '0 ##1 periph_rst_hold_q == '0)
		else $error("disable bits not cleared by reset");
	// Hold only moves with an accepted write, never on its own
	a_hold_on_write: assert property (
		$changed(periph_rst_hold_q) |-> $rose(bvalid))
		else $error("reset hold changed without a write");
	a_route_en_owner: assert property (
		in_route_en_q == exp_en)
		else $error("input route enable wrong");
	a_src_owner_off: assert property (
		!bad_src)
		else $error("output source of disabled peripheral visible");
	// Output enable is registered: inputs settle two edges, previous edge out of reset
	a_dir_override: assert property (
		($stable(pin_direction_control) && $stable(periph_dir_ovr)
		&& $stable(periph_dir_drive) && $stable(out_src_q))[*2]
		##0 ($past(aresetn) && $past(por_bor_resetn)) |-> pin_oe_n_q == exp_oe)
		else $error("pin output enable wrong");

	c_sysclk_off: cover property (!peripheral_sysclk_gate_q);
	c_route_off: cover property (!in_route_en_q[1]);
	c_src_live: cover property (out_src_q[4:0] == 5'h19);
endmodule

bind pmd_top pmd_top_chk #(.N_IN(N_IN), .N_PIN(N_PIN)) u_chk (.aclk, .aresetn,
	.por_bor_resetn, .bvalid, .periph_clk_en_q, .periph_rst_hold_q, .peripheral_sysclk_gate_q,
	.in_route_en_q, .out_src_q, .pin_direction_control, .periph_dir_ovr, .periph_dir_drive,
	.pin_oe_n_q);

// ==== verif/pmd_top_tb.sv ====
// Testbench: disable controls, routing registers and lock sequence over the bus
`timescale 1ns/10ps
module pmd_top_tb;
	localparam logic [7:0] MSK [6] = '{8'hc7, 8'h87, 8'h67, 8'h3f, 8'hd1, 8'h1e};
	// Defaults that agree across part variants; 8'hff entries are skipped
	localparam logic [7:0] DFL [20] = '{8'h02, 8'h02, 8'h05, 8'h04, 8'h05, 8'h15, 8'h13,
		8'h02, 8'hff, 8'hff, 8'hff, 8'hff, 8'h12, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h11, 8'h10};
	logic aclk = '0;
	logic aresetn = '0;
	logic por_bor_resetn = '0;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0, one_shot = '0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, ovr = '0, drv = '0;
	logic [31:0] seed = 32'h2ae30222, bg = 32'h2ae30222;
	logic [17:0] pin_dir = '0;
	logic awready, wready, bvalid, arready, rvalid, sys_gate;
	logic [1:0] bresp, rresp, rd_r, wr_r;
	logic [31:0] rdata, rd_v;
	logic [47:0] hold;
	logic [19:0] route_en;
	logic [89:0] out_src;
	logic [119:0] in_sel;
	int errors = 0;
	int samples_checked = 0;

	pmd_top u_dut (.aclk, .aresetn, .por_bor_resetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .one_shot_route_lock(one_shot),
		.periph_clk_en_q(), .periph_rst_hold_q(hold), .peripheral_sysclk_gate_q(sys_gate),
		.in_sel_q(in_sel), .in_route_en_q(route_en), .out_src_q(out_src),
		.pin_direction_control(pin_dir), .periph_dir_ovr(ovr), .periph_dir_drive(drv),
		.pin_oe_n_q());

	always #10 aclk = ~aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Direction inputs wander now and then; code 0 never claims a pin
	always @(posedge aclk) begin
		bg <= lfsr(bg);
		if (bg[3:0] == 4'h0) begin
			pin_dir <= bg[31:14];
			ovr <= {bg[15:0], bg[31:17], 1'h0};
			drv <= ~bg;
		end
	end

	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Offers address and data together, drops each once taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {20'h0, a};
		wdata <= {24'h0, d};
		awvalid <= '1;
		wvalid <= '1;
		bready <= '1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= '0;
			if (wready)
				wvalid <= '0;
		end while (!bvalid);
		bready <= '0;
		wr_r = bresp;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= {20'h0, a};
		arvalid <= '1;
		rready <= '1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= '0;
		end while (!rvalid);
		rready <= '0;
		rd_v = rdata;
		rd_r = rresp;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk(nm, rd_v, e);
	endtask

	task automatic key(input logic [7:0] d);
		wr(12'h018, 8'h55);
		wr(12'h018, 8'haa);
		wr(12'h018, d);
	endtask

	task automatic rst(input logic por);
		@(posedge aclk);
		aresetn <= '0;
		por_bor_resetn <= !por;
		repeat (3) @(posedge aclk);
		aresetn <= '1;
		por_bor_resetn <= '1;
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		end_of_test;
	end

	initial begin
		logic [7:0] v;
		repeat (3) @(posedge aclk);
		aresetn <= '1;
		por_bor_resetn <= '1;
		for (int n = 0; n < 6; n++)
			rdc(12'(4 * n), '0, "disable reset");
		rdc(12'h018, '0, "lock reset");
		rdc(12'h13c, '0, "source reset");
		for (int i = 0; i < 20; i++)
			if (DFL[i] != 8'hff)
				rdc(12'h040 + 12'(4 * i), {24'h0, DFL[i]}, "input default");
		rd(12'h3fc);
		chk("unmapped resp", {30'h0, rd_r}, 32'h2);
		wr(12'h3fc, 8'h00);
		chk("unmapped write", {30'h0, wr_r}, 32'h2);
		$display("test reset values done");
		// Random then all-ones patterns; all-ones also stops the system clock
		for (int p = 0; p < 2; p++)
			for (int n = 0; n < 6; n++) begin
				seed = lfsr(seed);
				v = p ? 8'hff : seed[7:0];
				wr(12'(4 * n), v);
				chk("hold", {24'h0, hold[8*n+:8]}, {24'h0, v & MSK[n]});
				rdc(12'(4 * n), {24'h0, v & MSK[n]}, "disable readback");
			end
		chk("sysclk gate", {31'h0, sys_gate}, '0);
		for (int n = 0; n < 6; n++)
			wr(12'(4 * n), 8'h00);
		repeat (50) @(posedge aclk);
		$display("test disable bits done");
		wr(12'h100, 8'h19);
		wr(12'h004, 8'h01);
		chk("route enable", {31'h0, route_en[1]}, '0);
		chk("source gated", {27'h0, out_src[4:0]}, '0);
		wr(12'h044, 8'h07);
		rdc(12'h044, '0, "select off");
		rdc(12'h100, '0, "source off");
		wr(12'h004, 8'h00);
		repeat (2) @(posedge aclk);
		rdc(12'h044, 32'h2, "select kept");
		chk("source back", {27'h0, out_src[4:0]}, 32'h19);
		$display("test disabled routing done");
		key(8'h01);
		chk("lock write resp", {30'h0, wr_r}, '0);
		rdc(12'h018, 32'h1, "locked");
		wr(12'h044, 8'h09);
		wr(12'h104, 8'h05);
		rdc(12'h044, 32'h2, "select locked");
		rdc(12'h104, '0, "source locked");
		wr(12'h008, 8'h20);
		rdc(12'h008, 32'h20, "disable while locked");
		// A foreign write between the keys must void the sequence
		wr(12'h018, 8'h55);
		wr(12'h008, 8'h00);
		wr(12'h018, 8'haa);
		wr(12'h018, 8'h00);
		rdc(12'h018, 32'h1, "broken key");
		key(8'h00);
		rdc(12'h018, '0, "unlocked");
		wr(12'h044, 8'hcf);
		rdc(12'h044, 32'hf, "select width");
		chk("select output", {26'h0, in_sel[6+:6]}, 32'hf);
		wr(12'h108, 8'hf9);
		rdc(12'h108, 32'h19, "source width");
		$display("test lock done");
		one_shot <= '1;
		repeat (3) @(posedge aclk);
		key(8'h01);
		key(8'h00);
		rdc(12'h018, 32'h1, "one shot");
		wr(12'h000, 8'h80);
		rst(1'b0);
		rdc(12'h000, '0, "disable cleared");
		rdc(12'h018, '0, "lock cleared");
		rdc(12'h044, 32'hf, "select survives");
		rdc(12'h108, 32'h19, "source survives");
		rst(1'b1);
		rdc(12'h044, 32'h2, "select power on");
		rdc(12'h108, '0, "source power on");
		$display("test resets done");
		end_of_test;
	end
endmodule
